// ===== vtt_pkg.sv
// package for the trail termination block: frame layout, register map, carriers
package vtt_pkg;
    // -----------------------------------------------------------------
    // frame layout (byte index from the frame start, first byte is V5)
    // -----------------------------------------------------------------
    localparam logic [7:0] FRAME_BYTES = 8'd140;
    localparam logic [7:0] POS_V5 = 8'd0;
    localparam logic [7:0] POS_J2 = 8'd35;
    localparam logic [7:0] POS_K4 = 8'd105;
    localparam int FRAME_US = 500;
    localparam int SECOND_US = 1000000;
    localparam int FRAMES_PER_SEC = SECOND_US / FRAME_US;
    localparam logic [1:0] TRACE_ACCEPT = 2'd3;
    localparam logic [7:0] ALL_ONES_BYTE = 8'hFF;
    localparam logic [2:0] LABEL_UNEQ = 3'h0;

    // -----------------------------------------------------------------
    // register byte offsets
    // -----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TX_TRACE = 8'h04;
    localparam logic [7:0] OFS_EXP_TRACE = 8'h08;
    localparam logic [7:0] OFS_DEG_THR = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_ACC_TRACE = 8'h14;
    localparam logic [7:0] OFS_NEAR_EBC = 8'h18;
    localparam logic [7:0] OFS_FAR_EBC = 8'h1C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h24;
    localparam logic [7:0] OFS_IRQ_EN = 8'h28;

    // control register fields
    localparam int CTRL_MONITORED = 0;
    localparam int CTRL_SSF_REP = 1;
    localparam int CTRL_RDI_REP = 2;
    localparam int CTRL_K4_ONES = 3;
    localparam int CTRL_TIM_DIS = 4;
    localparam int CTRL_W = 5;
    localparam int IRQ_W = 6;

    // -----------------------------------------------------------------
    // carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic ck;            // vc-12 byte clock from the link
        logic [7:0] so_data; // adapted data into the source
        logic so_fs;         // source frame start
        logic [7:0] sk_data; // connection data into the sink
        logic sk_fs;         // sink frame start
        logic ssf;           // incoming server fail
        logic hw_fault;      // hardware fault defect
    } vtt_link_in_s;

    typedef struct packed {
        logic [7:0] data;
        logic fs;
        logic ck;
    } vtt_stream_s;
endpackage : vtt_pkg

// ===== vtt_trail_term.sv
// vc-12 trail termination: overhead insertion, overhead checking, defects and counts
`timescale 1ns/1ps

// Summary of operation
// - source puts sent trace into J2
// - V5 bit 3 set when error count nonzero
// - V5 bit 8 follows remote defect request
// - V5 bits 1-2 carry previous frame parity
// - K4 bits 5-7 are 000 or 111
// - sink accepts J2 trace, shows it out
// - sink parity mismatch flags near block error
// - received V5 bit 3 is far error
// - received V5 bit 8 is remote defect
// - sink ignores K4 bits 5-8
// - V5 bits 5-7 feed unequipped detection
// - detect worsening, remote, unequipped, mismatch defects
// - derive all-ones, fail, request, worsening, error actions
// - all-ones output follows its action quickly
// - report unequipped, mismatch, worsening with priority
// - remote defect and server fail reports gated
// - defect seconds and block error counts
module vtt_trail_term #(
    parameter int FRAMES_PER_SEC = vtt_pkg::FRAMES_PER_SEC,
    parameter int CNT_W = 16
) (
    input wire logic pclk,                                   // apb clock, 50 MHz
    input wire logic presetn,                                // async reset, low
    input wire logic psel,                                   // apb select
    input wire logic penable,                                // apb enable
    input wire logic pwrite,                                 // apb direction
    input wire logic [7:0] paddr,                            // apb byte address
    input wire logic [31:0] pwdata,                          // apb write data
    output logic [31:0] prdata,                              // apb read data
    output logic pready,                                     // apb ready
    output logic pslverr,                                    // unmapped access
    input wire vtt_pkg::vtt_link_in_s link_in,               // link pins
    output vtt_pkg::vtt_stream_s so_out,                     // source output stream
    output vtt_pkg::vtt_stream_s sk_out,                     // sink output stream
    output logic outgoing_trail_fail,                        // trail fail to adaptation
    output logic outgoing_trail_worsening,                   // degrade to adaptation
    output logic [1:0] remote_error_count_to_source,         // per-frame error count
    output logic remote_defect_request_to_source,            // remote defect request
    output logic [7:0] accepted_trace_id,                    // accepted trace
    output logic irq                                         // level interrupt
);
    import vtt_pkg::*;

    typedef struct packed {
        vtt_link_in_s s1;
        vtt_link_in_s s2;
        logic ck_prev;
        vtt_stream_s so;
        vtt_stream_s sk;
        logic [7:0] so_pos;
        logic [7:0] sk_pos;
        logic [1:0] so_acc;
        logic [1:0] sk_acc;
        logic [CTRL_W-1:0] ctrl;
        logic [7:0] sent_trace;
        logic [7:0] exp_trace;
        logic [7:0] rx_trace;
        logic [7:0] acc_trace;
        logic [1:0] trace_cnt;
        logic [1:0] rei_cnt;
        logic rdi_bit;
        logic uneq;
        logic worse;
        logic [CNT_W-1:0] deg_thr;
        logic [CNT_W-1:0] sec_err;
        logic [CNT_W-1:0] near_ebc;
        logic [CNT_W-1:0] far_ebc;
        logic [CNT_W-1:0] frame_cnt;
        logic near_ds_acc;
        logic far_ds_acc;
        logic near_ds;
        logic far_ds;
        logic [IRQ_W-2:0] rep_prev;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
    } vtt_state_s;

    vtt_state_s state_q;
    vtt_state_s state_d;

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    // even parity of odd bits (1,3,5,7) and even bits (2,4,6,8), msb = bit 1
    function automatic logic [1:0] vtt_bip(input logic [7:0] b);
        vtt_bip = {b[7] ^ b[5] ^ b[3] ^ b[1], b[6] ^ b[4] ^ b[2] ^ b[0]};
    endfunction : vtt_bip

    // saturating add so long runs never wrap to a small count
    function automatic logic [CNT_W-1:0] vtt_add(input logic [CNT_W-1:0] c, input logic [1:0] inc);
        logic [CNT_W:0] s;
        s = {1'b0, c} + {{(CNT_W - 1){1'b0}}, inc};
        vtt_add = s[CNT_W] ? {CNT_W{1'b1}} : s[CNT_W-1:0];
    endfunction : vtt_add

    // next byte position in the frame; frame start forces the V5 slot
    function automatic logic [7:0] vtt_next_pos(input logic fs, input logic [7:0] pos);
        if (fs || pos == FRAME_BYTES - 8'd1) begin
            vtt_next_pos = POS_V5;
        end else begin
            vtt_next_pos = pos + 8'd1;
        end
    endfunction : vtt_next_pos

    // -----------------------------------------------------------------
    // defects, actions and correlations
    // -----------------------------------------------------------------
    logic monitored;
    logic tim_defect;
    logic force_ones;
    logic trail_fail;
    logic [IRQ_W-2:0] reports;
    logic strike;
    logic apb_wr;
    logic [IRQ_W-1:0] events;

    assign monitored = state_q.ctrl[CTRL_MONITORED];
    assign tim_defect = ~state_q.ctrl[CTRL_TIM_DIS] && (state_q.acc_trace != state_q.exp_trace);
    assign force_ones = state_q.uneq | tim_defect;
    assign trail_fail = state_q.s2.ssf | state_q.uneq | tim_defect;
    // report order: unequipped, mismatch, worsening, remote defect, server fail
    assign reports[0] = state_q.uneq & monitored;
    assign reports[1] = tim_defect & ~state_q.uneq & monitored;
    assign reports[2] = state_q.worse & ~tim_defect & monitored;
    assign reports[3] = state_q.rdi_bit & ~state_q.uneq & ~tim_defect & monitored
                        & state_q.ctrl[CTRL_RDI_REP];
    assign reports[4] = state_q.s2.ssf & monitored & state_q.ctrl[CTRL_SSF_REP];

    // link byte clock edge, seen only after the synchroniser
    assign strike = state_q.s2.ck & ~state_q.ck_prev;
    assign apb_wr = psel & penable & pwrite;

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign so_out = state_q.so;
    assign sk_out = state_q.sk;
    assign outgoing_trail_fail = trail_fail;
    assign outgoing_trail_worsening = state_q.worse;
    assign remote_error_count_to_source = state_q.rei_cnt;
    assign remote_defect_request_to_source = trail_fail;
    assign accepted_trace_id = state_q.acc_trace;
    assign irq = |(state_q.irq_stat & state_q.irq_en);
    assign pready = 1'b1;

    // apb read mux and unmapped address answer, zero wait states
    always_comb begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        case (paddr)
            OFS_CTRL: prdata[CTRL_W-1:0] = state_q.ctrl;
            OFS_TX_TRACE: prdata[7:0] = state_q.sent_trace;
            OFS_EXP_TRACE: prdata[7:0] = state_q.exp_trace;
            OFS_DEG_THR: prdata[CNT_W-1:0] = state_q.deg_thr;
            OFS_STATUS: prdata[11:0] = {trail_fail, state_q.far_ds, state_q.near_ds, reports,
                                        state_q.rdi_bit, state_q.worse, tim_defect, state_q.uneq};
            OFS_ACC_TRACE: prdata[7:0] = state_q.acc_trace;
            OFS_NEAR_EBC: prdata[CNT_W-1:0] = state_q.near_ebc;
            OFS_FAR_EBC: prdata[CNT_W-1:0] = state_q.far_ebc;
            OFS_IRQ_STAT: prdata[IRQ_W-1:0] = state_q.irq_stat;
            OFS_IRQ_CLR: prdata = 32'h0000_0000; // write-only, reads zero
            OFS_IRQ_EN: prdata[IRQ_W-1:0] = state_q.irq_en;
            default: pslverr = psel & penable;
        endcase
    end

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        logic [7:0] b;
        logic [7:0] r;
        logic [7:0] pos;
        logic [1:0] viol;
        logic tick;
        b = 8'h00;
        r = 8'h00;
        pos = 8'h00;
        viol = 2'b00;
        tick = 1'b0;
        state_d = state_q;

        // two-flop synchroniser on every link pin
        state_d.s1 = link_in;
        state_d.s2 = state_q.s1;
        state_d.ck_prev = state_q.s2.ck;
        // output clocks lag the data by one cycle so data is stable at their edge
        state_d.so.ck = state_q.ck_prev;
        state_d.sk.ck = state_q.ck_prev;

        // source: overhead insertion, one byte per link clock
        if (strike) begin
            pos = vtt_next_pos(state_q.s2.so_fs, state_q.so_pos);
            b = state_q.s2.so_data;
            case (pos)
                POS_V5: begin
                    b[7:6] = state_q.so_acc;
                    b[5] = |state_q.rei_cnt;
                    b[0] = trail_fail;
                end
                POS_J2: begin
                    b = state_q.sent_trace;
                end
                POS_K4: begin
                    b[3:1] = {3{state_q.ctrl[CTRL_K4_ONES]}};
                end
                default: begin
                    b = state_q.s2.so_data;
                end
            endcase
            // parity restarts with V5 so it covers the whole frame as sent
            state_d.so_acc = (pos == POS_V5) ? vtt_bip(b) : state_q.so_acc ^ vtt_bip(b);
            state_d.so_pos = pos;
            state_d.so.data = b;
            state_d.so.fs = (pos == POS_V5);
        end

        // sink: overhead checking and data out
        if (strike) begin
            pos = vtt_next_pos(state_q.s2.sk_fs, state_q.sk_pos);
            r = state_q.s2.sk_data;
            state_d.sk_acc = state_q.sk_acc ^ vtt_bip(r);
            // K4 carries nothing the sink uses; its slot passes untouched
            if (pos == POS_V5) begin
                viol = r[7:6] ^ state_q.sk_acc;
                state_d.sk_acc = vtt_bip(r);
                state_d.rei_cnt = {1'b0, viol[1]} + {1'b0, viol[0]};
                state_d.near_ebc = vtt_add(state_q.near_ebc, {1'b0, |viol});
                state_d.sec_err = vtt_add(state_q.sec_err, {1'b0, |viol});
                state_d.far_ebc = vtt_add(state_q.far_ebc, {1'b0, r[5]});
                state_d.rdi_bit = r[0];
                state_d.uneq = (r[3:1] == LABEL_UNEQ);
                if (state_q.frame_cnt == CNT_W'(FRAMES_PER_SEC - 1)) begin
                    state_d.frame_cnt = '0;
                    tick = 1'b1;
                end else begin
                    state_d.frame_cnt = state_q.frame_cnt + 1'b1;
                end
            end else if (pos == POS_J2) begin
                // trace taken only on the fourth equal frame in a row, so one hit does not flip it
                if (r != state_q.rx_trace) begin
                    state_d.rx_trace = r;
                    state_d.trace_cnt = 2'd1;
                end else if (state_q.trace_cnt != TRACE_ACCEPT) begin
                    state_d.trace_cnt = state_q.trace_cnt + 2'd1;
                end else begin
                    state_d.acc_trace = r;
                end
            end
            state_d.sk_pos = pos;
            state_d.sk.data = force_ones ? ALL_ONES_BYTE : r;
            state_d.sk.fs = (pos == POS_V5);
        end

        // one-second window: worsening and defect seconds
        state_d.near_ds_acc = state_q.near_ds_acc | trail_fail | state_q.s2.hw_fault;
        state_d.far_ds_acc = state_q.far_ds_acc | state_q.rdi_bit;
        if (tick) begin
            state_d.worse = (state_q.deg_thr != '0) && (state_d.sec_err >= state_q.deg_thr);
            state_d.sec_err = '0;
            state_d.near_ds = state_q.near_ds_acc;
            state_d.far_ds = state_q.far_ds_acc;
            state_d.near_ds_acc = 1'b0;
            state_d.far_ds_acc = 1'b0;
        end

        // register writes
        if (apb_wr) begin
            case (paddr)
                OFS_CTRL: state_d.ctrl = pwdata[CTRL_W-1:0];
                OFS_TX_TRACE: state_d.sent_trace = pwdata[7:0];
                OFS_EXP_TRACE: state_d.exp_trace = pwdata[7:0];
                OFS_DEG_THR: state_d.deg_thr = pwdata[CNT_W-1:0];
                OFS_NEAR_EBC: state_d.near_ebc = '0;
                OFS_FAR_EBC: state_d.far_ebc = '0;
                OFS_IRQ_EN: state_d.irq_en = pwdata[IRQ_W-1:0];
                default: state_d.ctrl = state_d.ctrl;
            endcase
        end

        // sticky events; a new event wins over a clear in the same cycle
        state_d.rep_prev = reports;
        events = {tick, reports & ~state_q.rep_prev};
        if (apb_wr && paddr == OFS_IRQ_CLR) begin
            state_d.irq_stat = (state_q.irq_stat & ~pwdata[IRQ_W-1:0]) | events;
        end else begin
            state_d.irq_stat = state_q.irq_stat | events;
        end
    end

    // -----------------------------------------------------------------
    // state register
    // -----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end
endmodule : vtt_trail_term

// ===== vtt_trail_term_checker.sv
// assertion checker bound to the trail termination block
`timescale 1ns/1ps
module vtt_trail_term_checker
    import vtt_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic pslverr, // unmapped access
    input wire vtt_pkg::vtt_link_in_s link_in, // link pins
    input wire vtt_pkg::vtt_stream_s so_out, // source stream
    input wire vtt_pkg::vtt_stream_s sk_out, // sink stream
    input wire logic outgoing_trail_fail, // trail fail
    input wire logic [1:0] remote_error_count_to_source, // error count
    input wire logic remote_defect_request_to_source, // defect request
    input wire logic irq // interrupt
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic so_ck_q, rdi_q;
    logic [7:0] so_idx_q;
    logic [11:0] rdi_cnt_q, ais_cnt_q;
    // ages of the request and of an all-ones cause; saturate so they never wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            so_ck_q <= 1'b0;
            rdi_q <= 1'b0;
            so_idx_q <= '0;
            rdi_cnt_q <= '0;
            ais_cnt_q <= '0;
        end else begin
            so_ck_q <= so_out.ck;
            rdi_q <= remote_defect_request_to_source;
            if (rdi_q != remote_defect_request_to_source) rdi_cnt_q <= '0;
            else if (rdi_cnt_q != 12'hFFF) rdi_cnt_q <= rdi_cnt_q + 12'd1;
            if (!outgoing_trail_fail || link_in.ssf) ais_cnt_q <= '0;
            else if (ais_cnt_q != 12'hFFF) ais_cnt_q <= ais_cnt_q + 12'd1;
            if (so_out.ck && !so_ck_q) so_idx_q <= so_out.fs ? 8'd1 : so_idx_q + 8'd1;
        end
    end
    sequence s_so_byte; so_out.ck && !so_ck_q; endsequence
    sequence s_sk_byte; $rose(sk_out.ck); endsequence
    sequence s_ssf_held; link_in.ssf [*6]; endsequence
    property p_fail_rdi; outgoing_trail_fail == remote_defect_request_to_source; endproperty
    a_fail_rdi: assert property (p_fail_rdi) else $error("trail fail and defect request differ");
    property p_tsf_ssf; s_ssf_held |-> outgoing_trail_fail; endproperty
    a_tsf_ssf: assert property (p_tsf_ssf) else $error("server fail did not raise trail fail");
    property p_ais; s_sk_byte and ais_cnt_q > 12'd20 |-> sk_out.data == ALL_ONES_BYTE; endproperty
    a_ais: assert property (p_ais) else $error("sink data not all ones");
    property p_rdi_ins; s_so_byte and so_out.fs && rdi_cnt_q > 12'd2400 |-> so_out.data[0] == rdi_q; endproperty
    a_rdi_ins: assert property (p_rdi_ins) else $error("sent remote defect bit stale");
    property p_k4; s_so_byte and so_idx_q == POS_K4 |-> so_out.data[3:1] inside {3'h0, 3'h7}; endproperty
    a_k4: assert property (p_k4) else $error("bad pattern in sent K4");
    property p_rei_range; remote_error_count_to_source <= 2'd2; endproperty
    a_rei_range: assert property (p_rei_range) else $error("error count above two");
    property p_unmapped; psel && penable && paddr > OFS_IRQ_EN |-> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");
    property p_irq_off; psel && penable && pwrite && paddr == OFS_IRQ_EN && pwdata[5:0] == 6'h0 |=> !irq; endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt high with all enables off");
endmodule : vtt_trail_term_checker
bind vtt_trail_term vtt_trail_term_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .link_in(link_in), .so_out(so_out),
    .sk_out(sk_out), .outgoing_trail_fail(outgoing_trail_fail), .irq(irq),
    .remote_error_count_to_source(remote_error_count_to_source),
    .remote_defect_request_to_source(remote_defect_request_to_source));

// ===== vtt_far_model.sv
// far-side model: connection function feeding the sink, adaptation feeding the source
`timescale 1ns/1ps
module vtt_far_model
    import vtt_pkg::*;
(
    input wire logic pclk, // bench clock
    input wire logic run, // start frames while high
    input wire logic [7:0] trace, // byte put in J2
    input wire logic [2:0] label, // V5 signal label
    input wire logic rdi, // V5 remote defect bit
    input wire logic bip_err, // flip one parity bit, flag far error
    input wire logic ssf, // server fail to the sink
    input wire logic hw_fault, // hardware fault defect
    output vtt_pkg::vtt_link_in_s link // link pins
);
    logic [2:0] ph = '0;
    logic [7:0] idx = '0;
    logic act = 1'b0;
    logic [1:0] acc = '0, prev = '0, bp;
    logic [7:0] b;
    initial link = '0;
    assign bp = {^(b & 8'hAA), ^(b & 8'h55)};
    // frame byte with overhead slots filled; K4 junk must not disturb the sink
    always_comb begin
        b = 8'h5A ^ idx;
        if (idx == POS_V5) b = {prev ^ {bip_err, 1'b0}, bip_err, 1'b0, label, rdi};
        if (idx == POS_J2) b = trace;
        if (idx == POS_K4) b = 8'hAF;
    end
    // byte clock of 8 pclk, still between frames when idle
    always @(posedge pclk) begin
        ph <= ph + 3'd1;
        link.ssf <= ssf;
        link.hw_fault <= hw_fault;
        if (ph == 3'd3) link.ck <= act;
        if (ph == 3'd7) begin
            link.ck <= 1'b0;
            act <= run || idx != 8'd0;
            if (run || idx != 8'd0) begin
                link.sk_data <= b;
                link.so_data <= 8'h5A ^ idx;
                link.sk_fs <= idx == POS_V5;
                link.so_fs <= idx == POS_V5;
                acc <= (idx == 8'd139) ? 2'h0 : acc ^ bp;
                if (idx == 8'd139) prev <= acc ^ bp;
                idx <= (idx == 8'd139) ? 8'd0 : idx + 8'd1;
            end else begin
                // released lines toggle so no stale byte looks valid
                link.sk_data <= ~link.sk_data;
                link.so_data <= ~link.so_data;
            end
        end
    end
endmodule : vtt_far_model

// ===== vtt_trail_term_tb.sv
// self-checking bench for the trail termination block
`timescale 1ns/1ps
module vtt_trail_term_tb;
    import vtt_pkg::*;
    localparam int FC = 1120; // clocks per frame
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdv;
    logic pready, pslverr, err, trail_fail, trail_worse, rdi_req, irq, so_ck_d;
    logic run = 1'b0, rdi = 1'b0, bip_err = 1'b0, ssf = 1'b0, mon_full = 1'b0, hwf = 1'b0;
    logic [7:0] trace = 8'h96, acc_trace, mon_idx, v5_seen, j2_seen, k4_seen;
    logic [2:0] label = 3'h2;
    logic [1:0] rei_cnt, mon_acc;
    vtt_link_in_s link_in;
    vtt_stream_s so_out, sk_out;
    int error_cnt = 0, check_count = 0, n;
    vtt_trail_term #(.FRAMES_PER_SEC(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_in(link_in), .so_out(so_out), .sk_out(sk_out), .outgoing_trail_fail(trail_fail),
        .outgoing_trail_worsening(trail_worse), .remote_error_count_to_source(rei_cnt),
        .remote_defect_request_to_source(rdi_req), .accepted_trace_id(acc_trace), .irq(irq));
    vtt_far_model i_far (.pclk(pclk), .run(run), .trace(trace), .label(label), .rdi(rdi), .bip_err(bip_err),
        .ssf(ssf), .hw_fault(hwf), .link(link_in));
    always #10 pclk = ~pclk;
    function automatic logic [1:0] bip(input logic [7:0] d);
        return {^(d & 8'hAA), ^(d & 8'h55)};
    endfunction : bip
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdv & m, e);
    endtask : rd
    task automatic frames(input int k);
        repeat (k * FC) @(posedge pclk);
    endtask : frames
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    // source output watch: parity over the whole previous frame, overhead bytes kept
    always @(posedge pclk) begin
        so_ck_d <= so_out.ck;
        if (so_out.ck && !so_ck_d) begin
            if (so_out.fs) begin
                if (mon_full) chk(32'(so_out.data[7:6]), 32'(mon_acc));
                mon_full <= 1'b1;
                mon_acc <= bip(so_out.data);
                mon_idx <= 8'd1;
                v5_seen <= so_out.data;
            end else begin
                mon_acc <= mon_acc ^ bip(so_out.data);
                mon_idx <= mon_idx + 8'd1;
                if (mon_idx == POS_J2) j2_seen <= so_out.data;
                if (mon_idx == POS_K4) k4_seen <= so_out.data;
            end
        end
    end
    // watchdog: whole sequence is about 31 frames
    initial begin
        #(100000 * 20);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(OFS_CTRL, 32'hFFFF_FFFF, 32'h0);
        rd(8'h40, 32'hFFFF_FFFF, 32'h0);
        chk(32'(err), 32'h1);
        wr(OFS_IRQ_EN, 32'h3F);
        wr(OFS_CTRL, 32'h7);
        rd(OFS_CTRL, 32'hFFFF_FFFF, 32'h7);
        wr(OFS_TX_TRACE, 32'hC3);
        wr(OFS_EXP_TRACE, 32'h96);
        run <= 1'b1;
        frames(7);
        chk(32'(acc_trace), 32'h96);
        chk(32'(j2_seen), 32'hC3);
        chk(32'(k4_seen[3:1]), 32'h0);
        rd(OFS_STATUS, 32'h802, 32'h0);
        wr(OFS_NEAR_EBC, 32'h0);
        wr(OFS_FAR_EBC, 32'h0);
        wr(OFS_CTRL, 32'hF);
        wr(OFS_DEG_THR, 32'h1);
        frames(2);
        chk(32'(k4_seen[3:1]), 32'h7);
        // one bad parity block, also flagged as a far error
        bip_err <= 1'b1;
        @(posedge link_in.sk_fs);
        bip_err <= 1'b0;
        repeat (60) @(posedge pclk);
        chk(32'(rei_cnt), 32'h1);
        repeat (FC) @(posedge pclk);
        chk(32'(v5_seen[5]), 32'h1);
        frames(1);
        chk(32'(v5_seen[5]), 32'h0);
        rd(OFS_NEAR_EBC, 32'hFFFF_FFFF, 32'h1);
        rd(OFS_FAR_EBC, 32'hFFFF_FFFF, 32'h1);
        for (n = 0; n < 10 * FC && trail_worse !== 1'b1; n++) @(posedge pclk);
        chk(32'(trail_worse), 32'h1);
        wr(OFS_DEG_THR, 32'h0);
        label <= 3'h0;
        frames(3);
        chk({30'h0, trail_fail, rdi_req}, 32'h3);
        chk(32'(sk_out.data), 32'(ALL_ONES_BYTE));
        chk(32'(v5_seen[0]), 32'h1);
        rd(OFS_STATUS, 32'h1B, 32'h11);
        chk(32'(irq), 32'h1);
        wr(OFS_CTRL, 32'h6);
        frames(1);
        rd(OFS_STATUS, 32'h1F1, 32'h1);
        wr(OFS_CTRL, 32'h7);
        label <= 3'h2;
        frames(3);
        chk({30'h0, trail_fail, v5_seen[0]}, 32'h0);
        rdi <= 1'b1;
        frames(2);
        rd(OFS_STATUS, 32'h88, 32'h88);
        wr(OFS_CTRL, 32'h3);
        rd(OFS_STATUS, 32'h88, 32'h8);
        rdi <= 1'b0;
        wr(OFS_CTRL, 32'h7);
        wr(OFS_EXP_TRACE, 32'h55);
        frames(1);
        rd(OFS_STATUS, 32'h822, 32'h822);
        chk(32'(sk_out.data), 32'(ALL_ONES_BYTE));
        // mismatch disable drops the defect and its consequences at once
        wr(OFS_CTRL, 32'h17);
        rd(OFS_STATUS, 32'h822, 32'h0);
        wr(OFS_EXP_TRACE, 32'h96);
        ssf <= 1'b1;
        frames(1);
        rd(OFS_STATUS, 32'h900, 32'h900);
        ssf <= 1'b0;
        frames(1);
        wr(OFS_IRQ_EN, 32'h1F);
        wr(OFS_IRQ_CLR, 32'h3F);
        chk(32'(irq), 32'h0);
        // six frames so a full one-second window sees both defects
        hwf <= 1'b1;
        rdi <= 1'b1;
        frames(6);
        rd(OFS_IRQ_STAT, 32'h20, 32'h20);
        rd(OFS_STATUS, 32'h600, 32'h600);
        wr(OFS_IRQ_EN, 32'h0);
        chk(32'(irq), 32'h0);
        tally_and_finish();
    end
endmodule : vtt_trail_term_tb
